// >>> common/sefe_pkg.sv
/*
 Package for the two-wire memory bus front end: address word layout,
 capacity codes, bus timing counts and the write-busy interval.
 Assumes a 10 MHz system clock on both ends.
*/
`default_nettype none
package sefe_pkg;
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned WORD_BITS       = 8;
	localparam logic [3:0]  DEV_TYPE_CODE   = 4'hA;
	localparam int unsigned TYPE_MSB        = 7;
	localparam int unsigned TYPE_LSB        = 4;
	localparam int unsigned SEL2_BIT        = 3;
	localparam int unsigned SEL1_BIT        = 2;
	localparam int unsigned SEL0_BIT        = 1;
	localparam int unsigned RW_BIT          = 0;
	localparam logic [3:0]  BIT_LAST        = 4'h7;
	localparam logic [3:0]  BIT_ACK         = 4'h8;
	// Capacity codes
	localparam logic [1:0]  CAP_2K          = 2'h0;
	localparam logic [1:0]  CAP_4K          = 2'h1;
	localparam logic [1:0]  CAP_8K          = 2'h2;
	localparam logic [1:0]  CAP_16K         = 2'h3;
	// Internal write time, longest, in microseconds
	localparam int unsigned WRITE_TIME_US   = 5000;
	localparam int unsigned WRITE_CYC       = WRITE_TIME_US * (CLK_HZ / 1_000_000);
	// Controller quarter period of the link clock (one of four phases per bit), in system cycles
	localparam int unsigned HALF_PERIOD_CYC = 20;
	localparam logic [7:0]  HALF_PERIOD     = 8'(HALF_PERIOD_CYC);
	localparam logic [3:0]  RECOVER_CLOCKS  = 4'h9;
	localparam logic [1:0]  BUF_DEPTH       = 2'h2;
endpackage
`default_nettype wire

// >>> common/sefe_if.sv
/*
 Two-wire link between controller and memory front end.
 Both lines are open drain with pull-ups; the interface resolves them.
*/
`timescale 1ns/1ps
`default_nettype none
interface sefe_if;
	logic scl_ctl_o;
	logic scl_ctl_oe;
	logic sda_ctl_o;
	logic sda_ctl_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	wire  scl;
	wire  sda;
	// Wired AND with pull-up: any enabled low driver wins
	assign scl = !(scl_ctl_oe && !scl_ctl_o);
	assign sda = !((sda_ctl_oe && !sda_ctl_o) || (sda_dev_oe && !sda_dev_o));
	modport ctl (output scl_ctl_o, scl_ctl_oe, sda_ctl_o, sda_ctl_oe, input scl, sda);
	modport dev (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface
`default_nettype wire

// >>> design/sefe_dev.sv
/*
 Memory-side front end of the two-wire bus: start/stop detection, word
 shifting, acknowledge, device address decode with page bits, write busy.
 Assumes bus lines arrive asynchronously and the far side keeps timing.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Data changes only while clock low
// - Data fall, clock high: start
// - Data rise, clock high: stop, standby
// - All items are eight-bit words
// - Device acknowledges low in ninth clock
// - Controller acknowledges or stops after reads
// - Standby at power-up and after stop
// - Controller recovers: nine clocks, then start (controller ends the recovery early once data samples high)
// - First word after start: device address
// - Top four bits fixed one-zero pattern
// - Smallest capacity compares three select pins
// - Second capacity: two pins, one page bit
// - Third capacity: one pin, two page bits
// - Largest capacity: three page bits
// - Page bits lead the word address
// - Last address bit: high read, low write
// - Match acknowledges, mismatch returns standby
// - Internal write finishes within five ms
// - Bus ignored during internal write
// - Polling acknowledged only after write done
module sefe_dev
	import sefe_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = WRITE_CYC
)(
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	sefe_if.dev             bus,
	input  wire logic [1:0] capacity_i,
	input  wire logic       select_pin_two_i,
	input  wire logic       select_pin_one_i,
	input  wire logic       select_pin_zero_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_first_o,
	input  wire logic       rx_ready_i,
	output logic [2:0]      page_bits_o,
	output logic            read_mode_o,
	output logic            active_o,
	output logic            busy_o
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_BUSY
	} sefe_state_t;

	typedef struct packed {
		logic [1:0]  scl_sy;
		logic [1:0]  sda_sy;
		logic        scl_d;
		logic        sda_d;
		sefe_state_t st;
		logic [3:0]  bitn;
		logic [7:0]  sh;
		logic        sda_oe;
		logic        wrote;
		logic [31:0] wcnt;
		logic [7:0]  b0_d;
		logic [7:0]  b1_d;
		logic [1:0]  cnt;
		logic        tx_rdy;
		logic        busy;
		logic [4:0]  strap_m;
		logic [4:0]  strap_s;
		logic        rx_valid;
		logic [7:0]  rx_data;
		logic        rx_first;
		logic [2:0]  page;
		logic        rd;
		logic        active;
	} sefe_dev_t;

	sefe_dev_t s_r, s_nxt;

	// Address match per capacity, pins compared only where wired
	function automatic logic addr_match(input logic [7:0] w, input logic [1:0] cap,
			input logic p2, input logic p1, input logic p0);
		logic m;
		m = (w[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE);
		unique case (cap)
			CAP_2K:  m = m && (w[SEL2_BIT] == p2) && (w[SEL1_BIT] == p1) && (w[SEL0_BIT] == p0);
			CAP_4K:  m = m && (w[SEL2_BIT] == p2) && (w[SEL1_BIT] == p1);
			CAP_8K:  m = m && (w[SEL2_BIT] == p2);
			CAP_16K: m = m;
		endcase
		return m;
	endfunction

	// Page bits kept only where a select bit is not compared
	function automatic logic [2:0] page_of(input logic [7:0] w, input logic [1:0] cap);
		logic [2:0] p;
		p = 3'h0;
		unique case (cap)
			CAP_2K:  p = 3'h0;
			CAP_4K:  p = {2'h0, w[SEL0_BIT]};
			CAP_8K:  p = {1'h0, w[SEL1_BIT], w[SEL0_BIT]};
			CAP_16K: p = w[SEL2_BIT:SEL0_BIT];
		endcase
		return p;
	endfunction

	logic rise;
	logic fall;
	logic start_c;
	logic stop_c;
	logic pop;
	logic [7:0] hd;

	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_sy = {s_r.scl_sy[0], bus.scl};
		s_nxt.sda_sy = {s_r.sda_sy[0], bus.sda};
		s_nxt.scl_d  = s_r.scl_sy[1];
		s_nxt.sda_d  = s_r.sda_sy[1];
		// Capacity and select straps are pins: two flops before decode
		s_nxt.strap_m = {capacity_i, select_pin_two_i, select_pin_one_i, select_pin_zero_i};
		s_nxt.strap_s = s_r.strap_m;
		rise    = s_r.scl_sy[1] && !s_r.scl_d;
		fall    = !s_r.scl_sy[1] && s_r.scl_d;
		start_c = s_r.scl_sy[1] && s_r.scl_d && s_r.sda_d && !s_r.sda_sy[1];
		stop_c  = s_r.scl_sy[1] && s_r.scl_d && !s_r.sda_d && s_r.sda_sy[1];
		pop     = 1'b0;
		hd      = s_r.b0_d;

		// Receiver drains the output word
		if (s_r.rx_valid && rx_ready_i) begin
			s_nxt.rx_valid = 1'b0;
		end

		if (s_r.st == ST_BUSY) begin
			// Bus blind while the internal write runs
			s_nxt.sda_oe = 1'b0;
			if (s_r.wcnt >= WRITE_CYCLES - 1) begin
				s_nxt.st   = ST_IDLE;
				s_nxt.wcnt = 32'h0;
			end else begin
				s_nxt.wcnt = s_r.wcnt + 32'h1;
			end
		end else if (stop_c) begin
			s_nxt.sda_oe = 1'b0;
			s_nxt.active = 1'b0;
			s_nxt.st     = (s_r.wrote) ? ST_BUSY : ST_IDLE;
			s_nxt.wrote  = 1'b0;
			s_nxt.wcnt   = 32'h0;
		end else if (start_c) begin
			s_nxt.sda_oe = 1'b0;
			s_nxt.st     = ST_ADDR;
			s_nxt.bitn   = 4'h0;
			s_nxt.wrote  = 1'b0; // Dummy write before a repeated start must not arm busy
			s_nxt.active = 1'b1;
		end else begin
			unique case (s_r.st)
				ST_IDLE: ;
				ST_ADDR, ST_WR: begin
					if (rise) begin
						s_nxt.sh   = {s_r.sh[6:0], s_r.sda_sy[1]};
						s_nxt.bitn = s_r.bitn + 4'h1;
					end
					if (fall && s_r.bitn == BIT_ACK) begin
						if (s_r.st == ST_ADDR) begin
							if (addr_match(s_r.sh, s_r.strap_s[4:3], s_r.strap_s[2],
									s_r.strap_s[1], s_r.strap_s[0])) begin
								s_nxt.sda_oe = 1'b1;
								s_nxt.page   = page_of(s_r.sh, s_r.strap_s[4:3]);
								s_nxt.rd     = s_r.sh[RW_BIT];
								s_nxt.st     = ST_ADDR_ACK;
							end else begin
								s_nxt.st     = ST_IDLE;
								s_nxt.active = 1'b0;
							end
						end else begin
							s_nxt.sda_oe   = 1'b1;
							s_nxt.rx_valid = 1'b1;
							s_nxt.rx_data  = s_r.sh;
							s_nxt.rx_first = !s_r.wrote;
							s_nxt.wrote    = 1'b1;
							s_nxt.st       = ST_WR_ACK;
						end
					end
				end
				ST_ADDR_ACK, ST_WR_ACK: begin
					if (fall) begin
						s_nxt.bitn = 4'h0;
						if (s_r.st == ST_ADDR_ACK && s_r.rd) begin
							s_nxt.sda_oe = (s_r.cnt != 2'h0) ? !hd[TYPE_MSB] : 1'b0;
							s_nxt.sh     = (s_r.cnt != 2'h0) ? {hd[6:0], 1'b1} : 8'hFF;
							pop          = (s_r.cnt != 2'h0);
							s_nxt.st     = ST_RD;
						end else begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st     = ST_WR;
						end
					end
				end
				ST_RD: begin
					if (rise) begin
						s_nxt.bitn = s_r.bitn + 4'h1;
					end
					if (fall) begin
						if (s_r.bitn == BIT_ACK) begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st     = ST_RD_ACK;
						end else begin
							s_nxt.sda_oe = !s_r.sh[TYPE_MSB];
							s_nxt.sh     = {s_r.sh[6:0], 1'b1};
						end
					end
				end
				ST_RD_ACK: begin
					if (rise) begin
						// Controller low means go on, high means it will stop
						s_nxt.st   = s_r.sda_sy[1] ? ST_IDLE : ST_ADDR_ACK;
						s_nxt.bitn = 4'h0;
					end
				end
				ST_BUSY: ;
			endcase
		end

		// Two-entry transmit buffer, filled from user side
		if (pop) begin
			s_nxt.b0_d = s_r.b1_d;
			s_nxt.cnt  = s_r.cnt - 2'h1;
		end
		if (tx_valid_i && s_r.cnt != BUF_DEPTH) begin
			if ((pop ? s_nxt.cnt : s_r.cnt) == 2'h0) begin
				s_nxt.b0_d = tx_data_i;
			end else begin
				s_nxt.b1_d = tx_data_i;
			end
			s_nxt.cnt = (pop ? s_nxt.cnt : s_r.cnt) + 2'h1;
		end
		// Status kept in flops so the outputs carry no decode glitches
		s_nxt.tx_rdy = (s_nxt.cnt != BUF_DEPTH);
		s_nxt.busy   = (s_nxt.st == ST_BUSY);
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r        <= '0;
			s_r.scl_sy <= 2'h3;
			s_r.sda_sy <= 2'h3;
			s_r.scl_d  <= 1'b1;
			s_r.sda_d  <= 1'b1;
			s_r.tx_rdy <= 1'b1;
			s_r.st     <= ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.sda_dev_o  = 1'b0;
	assign bus.sda_dev_oe = s_r.sda_oe;
	assign tx_ready_o     = s_r.tx_rdy;
	assign rx_valid_o     = s_r.rx_valid;
	assign rx_data_o      = s_r.rx_data;
	assign rx_first_o     = s_r.rx_first;
	assign page_bits_o    = s_r.page;
	assign read_mode_o    = s_r.rd;
	assign active_o       = s_r.active;
	assign busy_o         = s_r.busy;
endmodule
`default_nettype wire

// >>> design/sefe_ctl.sv
/*
 Controller end of the two-wire bus: makes the link clock by a divider,
 issues start, eight-bit words, stop and the recovery of up to nine clocks.
 Assumes the target stretches no clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sefe_ctl
	import sefe_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       nrst_i,
	sefe_if.ctl             bus,
	input  wire logic       cmd_valid_i,
	input  wire logic [2:0] cmd_op_i,
	input  wire logic [7:0] cmd_data_i,
	output logic            cmd_ready_o,
	output logic            rsp_valid_o,
	output logic [7:0]      rsp_data_o,
	output logic            rsp_ack_o
);
	// Ops: 0 start, 1 write byte, 2 read byte ack, 3 read byte nack, 4 stop, 5 recover
	localparam logic [2:0] OP_START = 3'h0;
	localparam logic [2:0] OP_WR    = 3'h1;
	localparam logic [2:0] OP_RDA   = 3'h2;
	localparam logic [2:0] OP_RDN   = 3'h3;
	localparam logic [2:0] OP_STOP  = 3'h4;
	localparam logic [2:0] OP_REC   = 3'h5;

	typedef enum logic [1:0] {C_IDLE, C_RUN} sefe_cst_t;
	typedef struct packed {
		sefe_cst_t  st;
		logic [2:0] op;
		logic [7:0] sh;
		logic [3:0] bitn;
		logic [1:0] ph;
		logic [7:0] tick;
		logic       scl;
		logic       sda;
		logic [1:0] sda_sy;
		logic       rv;
		logic       ack;
		logic [7:0] rd;
		logic       rdy;
	} sefe_ctl_t;
	sefe_ctl_t c_r, c_nxt;

	logic last_bit;

	// Each bit is four phases: set data, raise, sample, lower
	always_comb begin
		c_nxt = c_r;
		c_nxt.sda_sy = {c_r.sda_sy[0], bus.sda};
		c_nxt.rv = 1'b0;
		last_bit = 1'b0;
		unique case (c_r.st)
			C_IDLE: begin
				if (cmd_valid_i) begin
					c_nxt.st   = C_RUN;
					c_nxt.op   = cmd_op_i;
					c_nxt.sh   = cmd_data_i;
					c_nxt.bitn = 4'h0;
					c_nxt.ph   = 2'h0;
					c_nxt.tick = 8'h0;
				end
			end
			C_RUN: begin
				if (c_r.tick != HALF_PERIOD - 8'h1) begin
					c_nxt.tick = c_r.tick + 8'h1;
				end else begin
					c_nxt.tick = 8'h0;
					c_nxt.ph   = c_r.ph + 2'h1;
					unique case (c_r.ph)
						2'h0: begin
							unique case (c_r.op)
								OP_START: c_nxt.sda = 1'b1;
								OP_STOP:  c_nxt.sda = 1'b0;
								OP_REC:   c_nxt.sda = 1'b1;
								OP_WR:    c_nxt.sda = (c_r.bitn == BIT_ACK) ? 1'b1 : c_r.sh[TYPE_MSB];
								default:  c_nxt.sda = (c_r.bitn == BIT_ACK) ? (c_r.op == OP_RDN) : 1'b1;
							endcase
						end
						2'h1: c_nxt.scl = 1'b1;
						2'h2: begin
							if (c_r.op == OP_START) begin
								c_nxt.sda = 1'b0;
							end else if (c_r.op == OP_STOP) begin
								c_nxt.sda = 1'b1;
							end else if (c_r.op == OP_REC) begin
								// Released data high ends recovery early
								last_bit = c_r.sda_sy[1] || c_r.bitn == RECOVER_CLOCKS - 4'h1;
							end else if (c_r.bitn == BIT_ACK) begin
								c_nxt.ack = !c_r.sda_sy[1];
							end else begin
								c_nxt.rd = {c_r.rd[6:0], c_r.sda_sy[1]};
								c_nxt.sh = {c_r.sh[6:0], 1'b0};
							end
						end
						2'h3: begin
							if (c_r.op == OP_START || c_r.op == OP_STOP) begin
								last_bit = 1'b1;
								c_nxt.scl = (c_r.op == OP_STOP);
							end else begin
								c_nxt.scl  = 1'b0;
								c_nxt.bitn = c_r.bitn + 4'h1;
								last_bit = (c_r.op == OP_REC) ? (c_r.sda_sy[1] || c_r.bitn == RECOVER_CLOCKS - 4'h1)
									: (c_r.bitn == BIT_ACK);
							end
						end
					endcase
					if (last_bit && c_r.ph == 2'h3) begin
						c_nxt.st = C_IDLE;
						c_nxt.rv = 1'b1;
					end
				end
			end
			default: c_nxt.st = C_IDLE;
		endcase
		// Ready from a flop, decoded from the next state so it stays in step with the state
		c_nxt.rdy = (c_nxt.st == C_IDLE);
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			c_r        <= '0;
			c_r.st     <= C_IDLE;
			c_r.scl    <= 1'b1;
			c_r.sda    <= 1'b1;
			c_r.sda_sy <= 2'h3;
			c_r.rdy    <= 1'b1;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign bus.scl_ctl_o  = 1'b0;
	assign bus.scl_ctl_oe = !c_r.scl;
	assign bus.sda_ctl_o  = 1'b0;
	assign bus.sda_ctl_oe = !c_r.sda;
	assign cmd_ready_o    = c_r.rdy;
	assign rsp_valid_o    = c_r.rv;
	assign rsp_data_o     = c_r.rd;
	assign rsp_ack_o      = c_r.ack;
endmodule
`default_nettype wire

// >>> verif/sefe_props.sv
/*
 Checker on the two-wire link between the controller and memory ends.
 Assumes the 10 MHz system clock samples both lines, pull-ups on both.
*/
`timescale 1ns/1ps
`default_nettype none
module sefe_props (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe
);
	logic       scl_q;
	logic       sda_q;
	logic       adr_r;
	logic       rd_r;
	logic       idle_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	wire        rise = scl && !scl_q;
	wire        strt = scl && scl_q && sda_q && !sda;
	wire        stp  = scl && scl_q && !sda_q && sda;
	// Word tracking; bit count wraps on the rise after the ninth
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			adr_r <= 1'b0;
			rd_r <= 1'b0;
			idle_r <= 1'b1;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (strt) begin
				bit_r <= 4'h0;
				adr_r <= 1'b1;
				rd_r <= 1'b0;
				idle_r <= 1'b0;
			end else if (stp) begin
				idle_r <= 1'b1;
			end else if (rise) begin
				bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
				sh_r <= {sh_r[6:0], sda};
				if (bit_r == 4'h9) adr_r <= 1'b0;
				if (adr_r && bit_r == 4'h8) rd_r <= sh_r[0];
			end
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_drive_low;
		sda_dev_oe |-> !sda_dev_o;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("device drove the data line high");
	property p_change_low;
		$changed(sda_dev_oe) |-> !scl;
	endproperty
	a_change_low: assert property (p_change_low) else $error("device data changed with clock high");
	property p_addr_quiet;
		adr_r && bit_r < 4'h8 |-> !sda_dev_oe;
	endproperty
	a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address word");
	property p_wr_slot;
		!adr_r && !rd_r && sda_dev_oe |-> bit_r >= 4'h8;
	endproperty
	a_wr_slot: assert property (p_wr_slot) else $error("device drove inside a written word");
	property p_rd_release;
		!adr_r && rd_r && $rose(scl) && bit_r == 4'h8 |-> !sda_dev_oe;
	endproperty
	a_rd_release: assert property (p_rd_release) else $error("device held line in reader ack slot");
	property p_idle_quiet;
		idle_r |-> !sda_dev_oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("device drove while in standby");
	property p_ack_hold;
		$rose(scl) && bit_r == 4'h8 && sda_dev_oe |-> sda_dev_oe [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped in ninth clock");
	property p_type;
		adr_r && $rose(scl) && bit_r == 4'h8 && sh_r[7:4] != 4'hA |-> !sda_dev_oe;
	endproperty
	a_type: assert property (p_type) else $error("acknowledge on wrong type code");
	c_ack: cover property (adr_r && $rose(scl) && bit_r == 4'h8 && sda_dev_oe);
	c_read: cover property (!adr_r && rd_r && sda_dev_oe);
	c_stop: cover property (stp);
endmodule
`default_nettype wire

// >>> verif/sefe_tb.sv
/*
 Bench joining controller and memory ends over the link, with a model
 of decode, write path, busy interval and read path. Assumes 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sefe_tb;
	import sefe_pkg::*;
	localparam int WC = 2000; // Shortened write time keeps the run short
	logic       sys_clk_i = 0, nrst_i = 0, cmd_valid = 0, tx_valid = 0, rx_ready = 0;
	logic       p2 = 0, p1 = 0, p0 = 0;
	logic [1:0] cap = 0;
	logic [2:0] cmd_op = 0;
	logic [7:0] cmd_data = 0, tx_data = 0;
	wire logic  cmd_ready, rsp_valid, rsp_ack, tx_ready, rx_valid, rx_first, read_mode, active, busy;
	wire logic [7:0] rsp_data, rx_data;
	wire logic [2:0] page;
	int         n_fail = 0, compares = 0, cyc = 0;
	logic [8:0] got[$], exp[$];
	sefe_if lnk();
	sefe_ctl sefe_ctl_i (.sys_clk_i, .nrst_i, .bus(lnk.ctl), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
		.cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
		.rsp_ack_o(rsp_ack));
	sefe_dev #(.WRITE_CYCLES(WC)) sefe_dev_i (.sys_clk_i, .nrst_i, .bus(lnk.dev), .capacity_i(cap),
		.select_pin_two_i(p2), .select_pin_one_i(p1), .select_pin_zero_i(p0), .tx_valid_i(tx_valid),
		.tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.rx_first_o(rx_first), .rx_ready_i(rx_ready), .page_bits_o(page), .read_mode_o(read_mode),
		.active_o(active), .busy_o(busy));
	sefe_props sefe_props_i (.sys_clk_i, .nrst_i, .scl(lnk.scl), .sda(lnk.sda),
		.sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe));
	always #50 sys_clk_i = ~sys_clk_i;
	// Random receiver stalls; collect words; cut a hang short
	always @(posedge sys_clk_i) begin
		rx_ready <= 1'($urandom % 2);
		cyc <= cyc + 1;
		if (rx_valid && rx_ready) got.push_back({rx_first, rx_data});
		if (cyc == 60000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk_b(input string s, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic chk_f(input string s, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %b got %b", s, e, g);
		end
	endtask
	task automatic finish_test();
		if (n_fail == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One controller operation; waits for its response pulse
	task automatic op(input logic [2:0] c, input logic [7:0] d = 8'h00);
		int n;
		logic r;
		@(posedge sys_clk_i);
		cmd_valid <= 1'b1;
		cmd_op <= c;
		cmd_data <= d;
		do begin
			@(negedge sys_clk_i);
			r = cmd_ready;
			@(posedge sys_clk_i);
		end while (!r);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (rsp_valid !== 1'b1 && n < 1000);
		chk_f("rsp_valid", 1'b1, rsp_valid);
	endtask
	task automatic push(input logic [7:0] b);
		logic r;
		@(posedge sys_clk_i);
		tx_valid <= 1'b1;
		tx_data <= b;
		do begin
			@(negedge sys_clk_i);
			r = tx_ready;
			@(posedge sys_clk_i);
		end while (!r);
		tx_valid <= 1'b0;
	endtask
	function automatic logic [2:0] pmask(input int k);
		return 3'((8 >> (3 - k)) - 1);
	endfunction
	initial begin
		logic [7:0] a, b0, b1;
		logic [2:0] pins, m;
		logic       e;
		void'($urandom(32'h9864));
		repeat (16) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		op(3'h5);
		@(posedge sys_clk_i);
		// Decode across every capacity: match, random, wrong type code
		for (int k = 0; k < 16; k++) begin
			pins = 3'($urandom);
			cap <= 2'(k / 4);
			{p2, p1, p0} <= pins;
			a = {4'hA, 3'($urandom), 1'b0};
			if (k % 4 == 0) a[3:1] = pins;
			if (k % 4 == 3) a[7:4] = 4'($urandom) | 4'h1;
			m = pmask(k / 4);
			e = (a[7:4] == 4'hA) && (((a[3:1] ^ pins) & ~m) == 3'h0);
			op(3'h0);
			op(3'h1, a);
			chk_f("addr_ack", e, rsp_ack);
			if (e) chk_b("page", {5'h0, a[3:1] & m}, {5'h0, page});
			op(3'h4);
			repeat (5) @(posedge sys_clk_i);
			chk_f("standby", 1'b0, active);
		end
		// Write: word address plus two words, then busy and polling
		cap <= 2'h3;
		a = {4'hA, 3'($urandom), 1'b0};
		op(3'h0);
		op(3'h1, a);
		chk_f("wr_ack", 1'b1, rsp_ack);
		chk_f("rmode", 1'b0, read_mode);
		chk_b("wr_page", {5'h0, a[3:1]}, {5'h0, page});
		for (int i = 0; i < 3; i++) begin
			b0 = 8'($urandom);
			exp.push_back({i == 0, b0});
			op(3'h1, b0);
			chk_f("data_ack", 1'b1, rsp_ack);
		end
		op(3'h4);
		repeat (5) @(posedge sys_clk_i);
		chk_f("busy", 1'b1, busy);
		op(3'h0);
		op(3'h1, a);
		chk_f("poll", 1'b0, rsp_ack);
		op(3'h4);
		for (int n = 0; busy === 1'b1 && n < WC; n++) @(posedge sys_clk_i);
		chk_f("done", 1'b0, busy);
		op(3'h0);
		op(3'h1, a);
		chk_f("poll2", 1'b1, rsp_ack);
		op(3'h4);
		chk_b("rx_n", 8'h03, 8'(got.size()));
		for (int i = 0; i < 3; i++) begin
			chk_f("rx_first", exp[i][8], got[i][8]);
			chk_b("rx_data", exp[i][7:0], got[i][7:0]);
		end
		// Read: fill buffer until refused, drain past empty
		b0 = 8'($urandom);
		b1 = 8'($urandom);
		push(b0);
		push(b1);
		@(negedge sys_clk_i);
		chk_f("full", 1'b0, tx_ready);
		op(3'h0);
		op(3'h1, a | 8'h01);
		chk_f("rd_ack", 1'b1, rsp_ack);
		chk_f("rmode", 1'b1, read_mode);
		op(3'h2);
		chk_b("rd0", b0, rsp_data);
		op(3'h2);
		chk_b("rd1", b1, rsp_data);
		op(3'h3);
		chk_b("rd_empty", 8'hFF, rsp_data);
		op(3'h4);
		repeat (5) @(posedge sys_clk_i);
		chk_f("rd_standby", 1'b0, active);
		finish_test();
	end
endmodule
`default_nettype wire
